// file: hdl/smce_engine.v
`timescale 1ns/100ps
`include "smce_map.vh"
module smce_engine #(
  parameter BIT_CYCLES = `SMCE_BIT_CYCLES,
  parameter [15:0] SP_INIT = 16'h00ff
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire por_i,
  // Serial pins
  input wire serial_in_pin_i,
  output reg serial_out_pin_o,
  // Memory-system hooks
  input wire bulk_erase_i,
  input wire protected_i,
  input wire exec_protected_i,
  output reg return_from_interrupt_op_o,
  output wire illegal_addr_reset_o,
  output wire secure_ok_o
);
  localparam CW = 16;
  localparam S_SEC = 3'h0, S_RDY = 3'h1, S_OP = 3'h2, S_ARG = 3'h3, S_MEM = 3'h4, S_SEND = 3'h5;
  localparam [7:0] INVALID = 8'had;
  localparam integer BRK_CYCLES = BIT_CYCLES * `SMCE_BREAK_DELAY_BITS;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg [CW-1:0] rx_cnt;
  reg [3:0] rx_bit;
  reg [8:0] rx_sh;
  reg rx_busy;
  reg rx_done;
  reg rx_brk;
  reg [7:0] rx_byte;
  reg rx_hold;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt <= 16'h0000; rx_bit <= 4'h0; rx_sh <= 9'h000; rx_busy <= 1'b0;
      rx_done <= 1'b0; rx_brk <= 1'b0; rx_byte <= 8'h00; rx_hold <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_brk <= 1'b0;
      if (rx_hold) begin
        rx_hold <= ~serial_in_pin_i; // Line must rise before a new start bit
      end else if (!rx_busy) begin
        if (!serial_in_pin_i) begin
          rx_busy <= 1'b1;
          rx_cnt <= BIT_CYCLES[CW-1:0] + (BIT_CYCLES[CW-1:0] >> 1);
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt == 16'h0000) begin
        rx_sh <= {serial_in_pin_i, rx_sh[8:1]};
        rx_cnt <= BIT_CYCLES[CW-1:0] - 16'h0001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h8) begin
          rx_busy <= 1'b0;
          if (!serial_in_pin_i && rx_sh[8:1] == 8'h00) begin
            rx_brk <= 1'b1;
            rx_hold <= 1'b1;
          end else begin
            rx_done <= 1'b1;
            rx_byte <= rx_sh[8:1];
          end
        end
      end else begin
        rx_cnt <= rx_cnt - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Transmitter: byte or break
  // ----------------------------------------
  reg tx_go;
  reg tx_go_brk;
  reg [7:0] tx_data;
  reg [CW-1:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [9:0] tx_sh;
  reg tx_busy;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_cnt <= 16'h0000; tx_bit <= 4'h0; tx_sh <= 10'h3ff; tx_busy <= 1'b0;
      serial_out_pin_o <= 1'b1;
    end else if (!tx_busy) begin
      serial_out_pin_o <= 1'b1;
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_sh <= tx_go_brk ? 10'h000 : {1'b1, tx_data, 1'b0};
        tx_bit <= 4'h0;
        tx_cnt <= 16'h0000;
      end
    end else if (tx_cnt == 16'h0000) begin
      if (tx_bit == `SMCE_BREAK_LOW_BITS) begin
        tx_busy <= 1'b0;
        serial_out_pin_o <= 1'b1;
      end else begin
        serial_out_pin_o <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_bit <= tx_bit + 4'h1;
        tx_cnt <= BIT_CYCLES[CW-1:0] - 16'h0001;
      end
    end else begin
      tx_cnt <= tx_cnt - 16'h0001;
    end
  end

  // ----------------------------------------
  // Security state, POR only
  // ----------------------------------------
  reg sec_done;
  reg sec_ok;
  reg sec_upd;
  reg sec_res;
  always @(posedge sys_clk_i) begin
    if (por_i) begin
      sec_done <= 1'b0;
      sec_ok <= 1'b0;
    end else if (sec_upd) begin
      sec_done <= 1'b1;
      sec_ok <= sec_res;
    end
  end
  assign secure_ok_o = sec_ok;
  assign illegal_addr_reset_o = exec_protected_i & ~sec_ok;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  reg [2:0] state;
  reg [7:0] op;
  reg [1:0] argn;
  reg [15:0] addr;
  reg [15:0] last;
  reg [7:0] wdat;
  reg [3:0] sidx;
  reg [2:0] era_idx;
  reg [1:0] pend;
  reg pend_brk;
  reg [CW+1:0] brk_dly;
  reg mem_we;
  reg [15:0] mem_a;
  reg [7:0] mem_wd;
  reg mem_wait;
  reg [1:0] nsend;
  wire [7:0] mem_rd;

  smce_mem #(.AW(16)) u_mem (
    .sys_clk_i(sys_clk_i),
    .we_i(mem_we),
    .addr_i(mem_a),
    .wdata_i(mem_wd),
    .rdata_o(mem_rd)
  );

  wire [7:0] rd_val = (protected_i && !sec_ok) ? INVALID : mem_rd;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_SEC; op <= 8'h00; argn <= 2'h0; addr <= 16'h0000; last <= 16'h0000;
      wdat <= 8'h00; sidx <= 4'h0; sec_upd <= 1'b0; sec_res <= 1'b0; pend <= 2'h0; era_idx <= 3'h0;
      pend_brk <= 1'b0; brk_dly <= 18'h00000; tx_go <= 1'b0; tx_go_brk <= 1'b0;
      tx_data <= 8'h00; mem_we <= 1'b0; mem_a <= 16'h0000; mem_wd <= 8'h00;
      mem_wait <= 1'b0; nsend <= 2'h0; return_from_interrupt_op_o <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      tx_go_brk <= 1'b0;
      sec_upd <= 1'b0;
      mem_we <= 1'b0;
      mem_wait <= 1'b0;
      return_from_interrupt_op_o <= 1'b0;
      if (bulk_erase_i && !mem_we) begin
        mem_we <= 1'b1;
        mem_a <= `SMCE_SEC_BASE + {13'h0000, era_idx};
        mem_wd <= `SMCE_ERASED_BYTE;
        era_idx <= era_idx + 3'h1;
      end
      if (rx_done && !tx_busy && !tx_go) begin
        tx_go <= 1'b1;
        tx_data <= rx_byte;
      end
      if (rx_brk) begin
        brk_dly <= BRK_CYCLES[CW+1:0];
        pend_brk <= 1'b1;
      end else if (brk_dly != 0) begin
        brk_dly <= brk_dly - 1'b1;
      end else if (pend_brk && !tx_busy && !tx_go) begin
        pend_brk <= 1'b0;
        tx_go <= 1'b1;
        tx_go_brk <= 1'b1;
      end
      case (state)
        S_SEC: begin
          if (sec_done) begin
            state <= S_RDY;
          end else if (rx_done) begin
            mem_a <= `SMCE_SEC_BASE + {12'h000, sidx};
            wdat <= rx_byte;
            mem_wait <= 1'b1;
            state <= S_MEM;
            op <= 8'h00;
          end
        end
        S_RDY: begin
          if (!tx_busy && !tx_go && !pend_brk) begin
            tx_go <= 1'b1;
            tx_go_brk <= 1'b1;
            state <= S_OP;
            mem_we <= 1'b1;
            mem_a <= `SMCE_SEC_FLAG_ADDR;
            mem_wd <= {7'h00, sec_ok} << `SMCE_SEC_FLAG_BIT;
          end
        end
        S_OP: begin
          if (rx_done) begin
            op <= rx_byte;
            argn <= 2'h0;
            case (rx_byte)
              `SMCE_OP_READ, `SMCE_OP_WRITE: state <= S_ARG;
              `SMCE_OP_INDEXED_STORE: begin
                argn <= 2'h2;
                addr <= last + 16'h0001;
                state <= S_ARG;
              end
              `SMCE_OP_INDEXED_FETCH: begin
                addr <= last + 16'h0001;
                nsend <= 2'h2;
                pend <= 2'h1;
                state <= S_SEND;
              end
              `SMCE_OP_SP_FETCH: begin
                addr <= SP_INIT;
                nsend <= 2'h2;
                pend <= 2'h1;
                state <= S_SEND;
              end
              `SMCE_OP_RUN: return_from_interrupt_op_o <= 1'b1;
              default: state <= S_OP;
            endcase
          end
        end
        S_ARG: begin
          if (rx_done) begin
            argn <= argn + 2'h1;
            case (argn)
              2'h0: addr[15:8] <= rx_byte;
              2'h1: begin
                addr[7:0] <= rx_byte;
                if (op == `SMCE_OP_READ) begin
                  nsend <= 2'h1;
                  pend <= 2'h1;
                  state <= S_SEND;
                end
              end
              default: begin
                mem_we <= 1'b1;
                mem_a <= addr;
                mem_wd <= rx_byte;
                last <= addr;
                state <= S_OP;
              end
            endcase
          end
        end
        S_MEM: begin
          if (!mem_wait) begin
            if (mem_rd == wdat) begin
              if (sidx == 4'h0) begin
                sec_res <= 1'b1;
              end
            end else begin
              sec_res <= 1'b0;
            end
            if (sidx == `SMCE_SEC_COUNT - 4'h1) begin
              sidx <= 4'h0;
              sec_upd <= 1'b1;
              state <= S_RDY;
            end else begin
              sidx <= sidx + 4'h1;
              state <= S_SEC;
            end
          end else begin
            mem_wait <= 1'b0;
          end
        end
        S_SEND: begin
          mem_a <= addr;
          if (pend != 2'h0) begin
            pend <= pend - 2'h1;
          end else if (!tx_busy && !tx_go && !rx_busy && !rx_done) begin
            tx_go <= 1'b1;
            tx_data <= (op == `SMCE_OP_SP_FETCH) ? (nsend == 2'h2 ? SP_INIT[15:8] : SP_INIT[7:0]) : rd_val;
            if (op != `SMCE_OP_SP_FETCH) begin
              last <= addr;
            end
            addr <= addr + 16'h0001;
            pend <= 2'h2;
            nsend <= nsend - 2'h1;
            if (nsend == 2'h1) begin
              state <= S_OP;
            end
          end
        end
        default: state <= S_OP;
      endcase
    end
  end
endmodule // smce_engine

// file: hdl/smce_map.vh
`ifndef SMCE_MAP_VH
`define SMCE_MAP_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SMCE_OP_READ 8'h4a
`define SMCE_OP_WRITE 8'h49
`define SMCE_OP_INDEXED_FETCH 8'h1a
`define SMCE_OP_INDEXED_STORE 8'h19
`define SMCE_OP_SP_FETCH 8'h0c
`define SMCE_OP_RUN 8'h28
// ----------------------------------------
// Security
// ----------------------------------------
`define SMCE_SEC_BASE 16'hfff6
`define SMCE_SEC_COUNT 4'h8
`define SMCE_SEC_FLAG_ADDR 16'h0060
`define SMCE_SEC_FLAG_BIT 6
`define SMCE_ERASED_BYTE 8'hff
// ----------------------------------------
// Serial timing
// ----------------------------------------
`define SMCE_CLK_HZ 200000000
`define SMCE_BAUD 9600
`define SMCE_BIT_CYCLES (`SMCE_CLK_HZ / `SMCE_BAUD)
`define SMCE_BREAK_LOW_BITS 4'ha
`define SMCE_BREAK_DELAY_BITS 2
`endif

// file: hdl/smce_mem.v
`timescale 1ns/100ps
// ----------------------------------------
// Byte memory, registered read
// ----------------------------------------
module smce_mem #(
  parameter AW = 16
) (
  // Clock
  input wire sys_clk_i,
  // Access
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // smce_mem

// file: testbench/serial_monitor_command_engine_tb_top.sv
`timescale 1ns/100ps
module serial_monitor_command_engine_tb_top;
  localparam BC = 16;
  reg sys_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg por_i = 1'b1;
  reg bulk_erase_i = 1'b0;
  reg protected_i = 1'b0;
  reg exec_protected_i = 1'b0;
  wire rx;
  wire tx;
  wire run_pulse;
  wire ill;
  wire sec;
  integer fail_count = 0;
  integer comparisons = 0;
  integer pulses;
  reg [7:0] e;
  reg s;
  reg ok;
  always #2.5 sys_clk_i = ~sys_clk_i;
  smce_engine #(.BIT_CYCLES(BC)) dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .por_i(por_i),
    .serial_in_pin_i(rx), .serial_out_pin_o(tx), .bulk_erase_i(bulk_erase_i), .protected_i(protected_i),
    .exec_protected_i(exec_protected_i), .return_from_interrupt_op_o(run_pulse), .illegal_addr_reset_o(ill),
    .secure_ok_o(sec));
  smce_host #(.BC(BC)) host_u (.sys_clk_i(sys_clk_i), .tx_i(tx), .rx_o(rx));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task conclude;
    begin
      if (fail_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task get(input [7:0] exp, input stp);
    begin
      host_u.recv(e, s, ok);
      if (ok !== 1'b1) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t no character from device", $time);
        conclude;
      end
      chk(e, exp);
      chk({7'h00, s}, {7'h00, stp});
    end
  endtask
  task xfer(input [7:0] b);
    integer n;
    begin
      pulses = 0;
      fork
        host_u.send(b, 1'b1);
        get(b, 1'b1);
        for (n = 0; n < 12 * BC; n = n + 1) @(posedge sys_clk_i) if (run_pulse === 1'b1) pulses = pulses + 1;
      join
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      xfer(8'h49);
      xfer(a[15:8]);
      xfer(a[7:0]);
      xfer(d);
    end
  endtask
  task flag(input exp);
    begin
      xfer(8'h4a);
      xfer(8'h00);
      xfer(8'h60);
      host_u.recv(e, s, ok);
      chk({6'h00, ok, e[6]}, {6'h00, 1'b1, exp});
    end
  endtask
  task do_reset(input p);
    begin
      por_i <= p;
      rst_n_i <= 1'b0;
      repeat (20) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      por_i <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask
  task t_entry(input [7:0] key, input exp_sec);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) xfer(key);
      get(8'h00, 1'b0);
      repeat (2 * BC) @(posedge sys_clk_i);
      chk({7'h00, sec}, {7'h00, exp_sec});
    end
  endtask
  task t_mem;
    begin
      flag(1'b1);
      wr(16'h1235, 8'ha5);
      wr(16'h1233, 8'h11);
      xfer(8'h19);
      xfer(8'h77);
      wr(16'h1233, 8'h11);
      xfer(8'h1a);
      get(8'h77, 1'b1);
      get(8'ha5, 1'b1);
      wr(16'hffff, 8'h3e);
      wr(16'h0000, 8'h5c);
      wr(16'hfffe, 8'h00);
      xfer(8'h1a);
      get(8'h3e, 1'b1);
      get(8'h5c, 1'b1);
    end
  endtask
  task t_cmds;
    begin
      xfer(8'h55);
      chk(pulses[7:0], 8'h00);
      xfer(8'h28);
      chk(pulses[7:0], 8'h01);
    end
  endtask
  task t_break;
    integer n;
    begin
      n = 0;
      fork
        host_u.send(8'h00, 1'b0);
        get(8'h00, 1'b0);
        while (n < 14 * BC && tx !== 1'b0) begin
          @(posedge sys_clk_i);
          n = n + 1;
        end
      join
      comparisons = comparisons + 1;
      if (n < 11 * BC || n >= 13 * BC) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t break echo after %0d cycles", $time, n);
      end
      repeat (3 * BC) @(posedge sys_clk_i);
    end
  endtask
  task t_resets;
    begin
      do_reset(1'b0);
      get(8'h00, 1'b0);
      repeat (2 * BC) @(posedge sys_clk_i);
      chk({7'h00, sec}, 8'h01);
      do_reset(1'b1);
      t_entry(8'h00, 1'b0);
      flag(1'b0);
      exec_protected_i <= 1'b1;
      protected_i <= 1'b1;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk({7'h00, ill}, 8'h01);
      xfer(8'h1a);
      get(8'had, 1'b1);
      get(8'had, 1'b1);
    end
  endtask
  initial begin
    do_reset(1'b1);
    bulk_erase_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    bulk_erase_i <= 1'b0;
    t_entry(8'hff, 1'b1);
    t_mem;
    t_cmds;
    t_break;
    t_resets;
    conclude;
  end
endmodule // serial_monitor_command_engine_tb_top

// file: testbench/smce_engine_checker.sv
`timescale 1ns/100ps
module smce_engine_checker #(
  parameter BIT_CYCLES = 16
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire por_i,
  // Watched pins
  input wire serial_out_pin_o,
  input wire exec_protected_i,
  input wire return_from_interrupt_op_o,
  input wire illegal_addr_reset_o,
  input wire secure_ok_o
);
  localparam int MAX_LOW = 10 * BIT_CYCLES;
  reg [31:0] low_cnt;
  // Length of the current low run on the transmit pin
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 32'h00000000;
    end else begin
      low_cnt <= serial_out_pin_o ? 32'h00000000 : low_cnt + 32'h00000001;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_low_bit;
    !serial_out_pin_o [*8];
  endsequence
  sequence s_high_bit;
    serial_out_pin_o [*8];
  endsequence
  a_start_width: assert property ($fell(serial_out_pin_o) |-> s_low_bit)
    else $error("Transmit low level too short");
  a_stop_width: assert property ($rose(serial_out_pin_o) |-> s_high_bit)
    else $error("Transmit high level too short");
  a_break_length: assert property (low_cnt <= MAX_LOW)
    else $error("Transmit low longer than a break");
  a_illegal_exec: assert property (illegal_addr_reset_o == (exec_protected_i && !secure_ok_o))
    else $error("Illegal address reset mismatch");
  a_illegal_follows_secure: assert property ($rose(secure_ok_o) |-> !illegal_addr_reset_o)
    else $error("Illegal address reset while secure");
  a_run_single: assert property (return_from_interrupt_op_o |=> !return_from_interrupt_op_o)
    else $error("Run pulse longer than one cycle");
  a_secure_keep: assert property (secure_ok_o && !por_i |=> secure_ok_o)
    else $error("Security pass lost without power-on reset");
  a_idle_release: assert property ($rose(rst_n_i) |-> serial_out_pin_o && !return_from_interrupt_op_o)
    else $error("Outputs not idle after reset");
endmodule // smce_engine_checker

bind smce_engine smce_engine_checker #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .por_i(por_i),
  .serial_out_pin_o(serial_out_pin_o),
  .exec_protected_i(exec_protected_i),
  .return_from_interrupt_op_o(return_from_interrupt_op_o),
  .illegal_addr_reset_o(illegal_addr_reset_o),
  .secure_ok_o(secure_ok_o)
);

// file: testbench/smce_host.sv
`timescale 1ns/100ps
module smce_host #(
  parameter BC = 16
) (
  // Clock
  input wire sys_clk_i,
  // Serial lines
  input wire tx_i,
  output reg rx_o
);
  initial rx_o = 1'b1;
  // Start, eight data bits low first, stop; a low stop after all-zero data makes a break
  task send(input [7:0] b, input stp);
    integer i;
    reg [9:0] f;
    begin
      f = {stp, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        rx_o <= f[i];
        repeat (BC) @(posedge sys_clk_i);
      end
      rx_o <= 1'b1;
    end
  endtask
  // Mid-bit sampling of one character from the device
  task recv(output [7:0] b, output stp, output ok);
    integer n;
    integer i;
    begin
      ok = 1'b0;
      b = 8'h00;
      stp = 1'b0;
      for (n = 0; n < 40 * BC && !ok; n = n + 1) begin
        @(posedge sys_clk_i);
        if (tx_i === 1'b0) ok = 1'b1;
      end
      repeat (BC / 2) @(posedge sys_clk_i);
      for (i = 0; i < 8; i = i + 1) begin
        repeat (BC) @(posedge sys_clk_i);
        b[i] = tx_i;
      end
      repeat (BC) @(posedge sys_clk_i);
      stp = tx_i;
    end
  endtask
endmodule // smce_host
